// [rtl/bml_irq.sv]
// How it works
// - pins active low, two-flop synchronised first
// - after release pins become interrupt lines
// - each line maskable, level or falling edge
// - line zero low wakes core from stop
// - reset pin holds chip, clears phase generator
`timescale 1ns/10ps
module bml_irq #(
    parameter int LINES = bml_pkg::BML_LINES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic rst_pin_n,
    input wire logic [3:0] mode_irq_n,
    input wire bml_pkg::bml_ctrl_t ctrl,
    input wire logic in_stop,
    output logic chip_rst,
    output logic [1:0] phase,
    output logic [3:0] operating_mode_register,
    output logic [3:0] irq_req,
    output logic stop_wake
);
    import bml_pkg::*;

    // synchroniser stages; stage one is read only by stage two
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic rst_s1;
    logic rst_s2;
    // reset hold state
    logic held;      // chip held in reset
    logic held_prev; // held one cycle ago, for release detection
    logic run;       // mode latched, lines act as interrupts
    // interrupt side
    logic [3:0] pin_low;   // synchronised, active-high request level
    logic [3:0] low_prev;  // previous sample for edge detection
    logic [3:0] edge_pend; // sticky falling-edge requests
    logic release_pulse;   // first cycle out of reset

    // named copies of the shared pins, bit order as strapped
    logic boot_sel_bit0;
    logic boot_sel_bit1;
    logic boot_sel_bit2;
    logic boot_sel_bit3;
    logic ext_int_req_0;
    assign boot_sel_bit0 = pin_s2[0];
    assign boot_sel_bit1 = pin_s2[1];
    assign boot_sel_bit2 = pin_s2[2];
    assign boot_sel_bit3 = pin_s2[3];
    assign ext_int_req_0 = pin_low[0];

    // two flops before anything looks at the pins
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_s1 <= BML_SYNC_IDLE;
            pin_s2 <= BML_SYNC_IDLE;
        end else begin
            pin_s1 <= mode_irq_n;
            pin_s2 <= pin_s1;
        end
    end

    // reset pin synchroniser; idle state means reset asserted
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= rst_pin_n;
            rst_s2 <= rst_s1;
        end
    end

    assign pin_low = ~pin_s2;
    assign release_pulse = held_prev && !held;

    // hold the chip while either reset source is active
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            held <= 1'b1;
            held_prev <= 1'b1;
            chip_rst <= 1'b1;
        end else begin
            held <= !rst_s2;
            held_prev <= held;
            chip_rst <= !rst_s2;
        end
    end

    // phase generator restarts from zero whenever the chip is held
    always_ff @(posedge clk_sys) begin
        if (sys_rst || held) begin
            phase <= BML_PHASE_RST;
        end else begin
            phase <= phase + BML_PHASE_STEP;
        end
    end

    // mode latch: one capture per release, then frozen
    // a glitch on the straps after release cannot alter the mode
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            operating_mode_register <= BML_OMR_RST;
        end else if (release_pulse) begin
            operating_mode_register <= {boot_sel_bit3, boot_sel_bit2,
                                        boot_sel_bit1, boot_sel_bit0};
        end
    end

    // run flag marks the switch from strap to interrupt use
    always_ff @(posedge clk_sys) begin
        if (sys_rst || held) begin
            run <= 1'b0;
        end else if (release_pulse) begin
            run <= 1'b1;
        end
    end

    // previous level for falling-edge detection
    always_ff @(posedge clk_sys) begin
        if (sys_rst || held) begin
            low_prev <= BML_LINES_ZERO;
        end else begin
            low_prev <= pin_low;
        end
    end

    // one block per line: edge latch and request output
    genvar gi;
    generate
        for (gi = 0; gi < LINES; gi++) begin : g_line
            logic fell;
            assign fell = pin_low[gi] && !low_prev[gi];

            // sticky edge; a new edge in the ack cycle wins
            always_ff @(posedge clk_sys) begin
                if (sys_rst || !run) begin
                    edge_pend[gi] <= 1'b0;
                end else if (fell && ctrl.edge_sel[gi]) begin
                    edge_pend[gi] <= 1'b1;
                end else if (ctrl.ack[gi]) begin
                    edge_pend[gi] <= 1'b0;
                end
            end

            // request: masked, level or latched edge, only once running
            always_ff @(posedge clk_sys) begin
                // held covers the cycle before run drops, so requests clear one cycle after chip_rst rises
                if (sys_rst || held || !run) begin
                    irq_req[gi] <= 1'b0;
                end else if (!ctrl.mask_en[gi]) begin
                    irq_req[gi] <= 1'b0;
                end else if (ctrl.edge_sel[gi]) begin
                    irq_req[gi] <= edge_pend[gi];
                end else begin
                    irq_req[gi] <= pin_low[gi];
                end
            end
        end
    endgenerate

    // stop exit ignores the mask: a sleeping core has no way to unmask
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !run) begin
            stop_wake <= 1'b0;
        end else begin
            stop_wake <= in_stop && ext_int_req_0;
        end
    end

    // checks
    property p_sync_delay;
        @(posedge clk_sys) disable iff (sys_rst)
        (run && ctrl.mask_en[0] && !ctrl.edge_sel[0] && !mode_irq_n[0]) [*4] |-> irq_req[0];
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("level line did not request");

    property p_sync_not_early;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(irq_req[1]) && !$past(ctrl.edge_sel[1]) |-> !$past(mode_irq_n[1], 3);
    endproperty
    a_sync_not_early: assert property (p_sync_not_early) else $error("request ahead of sync");

    property p_mode_capture;
        @(posedge clk_sys) disable iff (sys_rst)
        held ##1 !held |=> operating_mode_register == $past(pin_s2);
    endproperty
    a_mode_capture: assert property (p_mode_capture) else $error("mode not latched");

    property p_mode_frozen;
        @(posedge clk_sys) disable iff (sys_rst)
        run && $past(run) |-> $stable(operating_mode_register);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed while running");

    property p_masked;
        @(posedge clk_sys) disable iff (sys_rst)
        !ctrl.mask_en[2] [*2] |-> !irq_req[2];
    endproperty
    a_masked: assert property (p_masked) else $error("masked line requested");

    property p_stop_wake;
        @(posedge clk_sys) disable iff (sys_rst)
        run && in_stop && pin_low[0] |=> stop_wake;
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("no stop exit");

    property p_reset_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        !rst_s2 |=> chip_rst ##1 (phase == BML_PHASE_RST && irq_req == BML_LINES_ZERO);
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset not held");

    property p_edge_sticky;
        @(posedge clk_sys) disable iff (sys_rst)
        run && edge_pend[3] && !ctrl.ack[3] |=> edge_pend[3] || !run;
    endproperty
    a_edge_sticky: assert property (p_edge_sticky) else $error("edge pending lost");

    c_release: cover property (@(posedge clk_sys) disable iff (sys_rst) release_pulse);
    c_edge_irq: cover property (@(posedge clk_sys) disable iff (sys_rst)
        ctrl.edge_sel[2] && irq_req[2]);
    c_level_irq: cover property (@(posedge clk_sys) disable iff (sys_rst)
        !ctrl.edge_sel[1] && irq_req[1]);
    c_wake: cover property (@(posedge clk_sys) disable iff (sys_rst) stop_wake);
endmodule : bml_irq

// [pkg/bml_pkg.sv]
// shared constants and carriers for the boot mode latch / external interrupt block
package bml_pkg;
    localparam int BML_LINES = 4;              // shared mode / interrupt pins
    localparam int BML_PHASE_W = 2;            // width of the clock phase generator
    localparam logic [3:0] BML_OMR_RST = 4'h0; // mode value before the first release
    localparam logic [3:0] BML_LINES_ZERO = 4'h0;
    localparam logic [1:0] BML_PHASE_RST = 2'h0;
    localparam logic [1:0] BML_PHASE_STEP = 2'h1;
    localparam logic [3:0] BML_SYNC_IDLE = 4'hF; // pins idle high before the first sample

    // per-line control bits, driven by core-side software logic
    typedef struct packed {
        logic [3:0] mask_en;  // 1 = line may request
        logic [3:0] edge_sel; // 1 = falling edge, 0 = low level
        logic [3:0] ack;      // one-cycle service strobe per edge line
    } bml_ctrl_t;
endpackage : bml_pkg

// [dv/bml_board.sv]
`timescale 1ns/10ps
// board straps and interrupt sources facing the shared pins
module bml_board (
    input wire logic clk_sys,
    input wire logic hold, // board keeps reset low
    input wire logic [3:0] strap, // mode code, high = 1
    input wire logic [3:0] irq_low, // 1 = source pulls line low
    output logic rst_pin_n,
    output logic [3:0] mode_irq_n
);
    logic [2:0] keep; // straps outlast the release: the latch sees synced pins late
    // count the strap hold time after the pin rises
    always_ff @(posedge clk_sys) begin
        if (hold) begin
            keep <= 3'h5;
        end else if (keep != 3'h0) begin
            keep <= keep - 3'h1;
        end
    end
    assign rst_pin_n = ~hold;
    // straps first, then the interrupt sources
    assign mode_irq_n = (hold || keep != 3'h0) ? strap : ~irq_low;
endmodule : bml_board

// [dv/bml_irq_test.sv]
`timescale 1ns/10ps
// self-checking bench for the mode latch and interrupt lines
module bml_irq_test;
    import bml_pkg::*;
    typedef struct packed {
        logic [3:0] mask; // lines enabled
        logic [3:0] lows; // lines pulled low
        logic [3:0] want; // expected requests
    } bml_row_t;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic hold = 1'b1; // board reset pin held
    logic [3:0] strap = 4'hA;
    logic [3:0] irq_low = 4'h0;
    logic in_stop = 1'b0;
    bml_ctrl_t ctrl = 12'hF00; // all lines enabled, level mode
    logic rst_pin_n;
    logic chip_rst;
    logic stop_wake;
    logic [3:0] mode_irq_n;
    logic [3:0] operating_mode_register;
    logic [3:0] irq_req;
    logic [1:0] phase;
    logic [1:0] ph;
    int checked = 0;
    int bad_count = 0;
    bml_row_t rows [4] = '{'{4'hF, 4'hA, 4'hA}, '{4'h3, 4'hF, 4'h3}, '{4'h0, 4'hF, 4'h0},
        '{4'hC, 4'h5, 4'h4}};
    // 25 ns period
    always #12.5 clk_sys = ~clk_sys;
    bml_irq u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n),
        .mode_irq_n(mode_irq_n), .ctrl(ctrl), .in_stop(in_stop), .chip_rst(chip_rst),
        .phase(phase), .operating_mode_register(operating_mode_register),
        .irq_req(irq_req), .stop_wake(stop_wake));
    bml_board u_board (.clk_sys(clk_sys), .hold(hold), .strap(strap), .irq_low(irq_low),
        .rst_pin_n(rst_pin_n), .mode_irq_n(mode_irq_n));
    // compare and count
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] want);
        checked++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    // inputs change on falling edges only
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    // release the board pin; bounded wait for the chip to run
    task automatic release_pin;
        hold = 1'b0;
        for (int i = 0; i < 10 && chip_rst !== 1'b0; i++) begin
            cyc(1);
        end
        if (chip_rst !== 1'b0) begin
            bad_count++;
            summarize();
        end
        cyc(2);
    endtask : release_pin
    initial begin
        cyc(12);
        check("chip_rst", chip_rst, 4'h1);
        check("phase", phase, 4'h0);
        sys_rst = 1'b0;
        cyc(4);
        check("chip_rst pin", chip_rst, 4'h1);
        check("irq held", irq_req, 4'h0);
        release_pin();
        check("mode", operating_mode_register, 4'hA);
        ph = phase + 2'h1; // one step per running cycle, wrapping at two bits
        cyc(1);
        check("phase step", phase, ph);
        cyc(6);
        // level rows: pins low on enabled lines request
        foreach (rows[i]) begin
            ctrl.mask_en = rows[i].mask;
            irq_low = rows[i].lows;
            cyc(5);
            check("level irq", irq_req, rows[i].want);
            check("mode kept", operating_mode_register, 4'hA);
            check("no wake", stop_wake, 4'h0);
            irq_low = 4'h0;
            cyc(5);
        end
        // short falling pulse on lines 2 and 3; an ack landing with the edge loses
        ctrl = 12'hFF0;
        irq_low = 4'hC;
        cyc(2);
        ctrl.ack = 4'hC;
        cyc(1);
        ctrl.ack = 4'h0;
        irq_low = 4'h0;
        cyc(4);
        check("edge pend", irq_req, 4'hC);
        ctrl.ack = 4'hC;
        cyc(1);
        ctrl.ack = 4'h0;
        cyc(3);
        check("edge ack", irq_req, 4'h0);
        // line zero wakes stop even when masked
        ctrl.mask_en = 4'h0;
        in_stop = 1'b1;
        irq_low = 4'h1;
        cyc(4);
        check("stop wake", stop_wake, 4'h1);
        check("masked", irq_req, 4'h0);
        irq_low = 4'h0;
        in_stop = 1'b0;
        // pin reset mid-run with a new strap code; level lines live so requests must clear
        ctrl = 12'hF00;
        strap = 4'h3;
        hold = 1'b1;
        cyc(4);
        check("pin reset", chip_rst, 4'h1);
        check("phase clr", phase, 4'h0);
        check("irq clr", irq_req, 4'h0);
        release_pin();
        check("mode again", operating_mode_register, 4'h3);
        summarize();
    end
endmodule : bml_irq_test
